/* logic/rpc_config_regs.v */
// Two subsystem configuration registers: MAC reduced interface setup and PHY power-on defaults.
// Assumes a simple synchronous register port from the management interface, strap sampled after reset.
//
// Operation
// [R1] Interface config register sits at 0xFF24 and resets to 0x0116.
// [R2] Bit 7 writable; setting it clears the receive FIFO; resets to zero.
// [R3] Bits 6:4 pick receive FIFO depth, four to 24 bits; 110/111 reserved.
// [R4] Bit 3 enables watching transmit data pins for frame start.
// [R5] Bit 2 folds carrier sense into combined carrier/data-valid; default on.
// [R6] Bit 1 set: receive error flagged on false carrier.
// [R7] Bit 1 clear: receive error only for symbol error within a frame.
// [R8] Bit 0 selects reduced interface mode; default loaded from strap pins.
// [R9] System must select reduced mode by straps, not software; the code also lets a write to bit 0 change it.
// [R10] Base config register sits at 0xFF26 and resets to 0x0C86.
// [R11] Bit 10 set enables enhanced link detection on 100BASE-TX link.
// [R12] Core software reset reloads the core link-detect enable from config.
// [R13] Config changes reach the core enable only at next core reset.
// [R14] Bit 3 set puts the PHY into power-down when leaving reset.
// [R15] Read-only reserved bits ignore writes and keep reset values.
`timescale 1ns/1ns
`include "rpc_regs.vh"
module rpc_config_regs (
    input wire mclk,
    input wire arst_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_addr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    output reg reg_rvalid,
    input wire strap_reduced_mode,
    input wire core_sw_reset,
    input wire link_100_up,
    input wire symbol_err,
    input wire false_carrier,
    input wire in_frame,
    input wire carrier_sense,
    input wire rx_data_valid,
    input wire [1:0] txd,
    output reg rx_fifo_clear,
    output reg [4:0] rx_fifo_depth_bits,
    output reg tx_data_frame_watch_en,
    output reg tx_frame_start,
    output reg crs_dv,
    output reg rx_er,
    output reg reduced_iface_mode_sel,
    output reg fast_link_detect_active,
    output reg sw_powerdown_out
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    reg rst_meta;
    reg rst_n;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------
    // Decoding
    // ----------------------------------------
    function [1:0] rpc_decode;
        input [15:0] a;
        begin
            if (a == `RPC_ADDR_IFACE_CFG) begin
                rpc_decode = 2'b01;
            end else if (a == `RPC_ADDR_BASE_CFG) begin
                rpc_decode = 2'b10;
            end else begin
                rpc_decode = 2'b00;
            end
        end
    endfunction

    function [4:0] rpc_depth;
        input [2:0] code;
        begin
            if (code > `RPC_DEPTH_MAX) begin
                rpc_depth = `RPC_DEPTH_BASE;
            end else begin
                rpc_depth = `RPC_DEPTH_BASE + code * `RPC_DEPTH_STEP;
            end
        end
    endfunction

    wire [1:0] sel = rpc_decode(reg_addr);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [15:0] iface_cfg;
    reg [15:0] base_cfg;
    reg strap_taken;
    reg txd_seen;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            iface_cfg <= `RPC_RST_IFACE_CFG; // [R1]
            base_cfg <= `RPC_RST_BASE_CFG; // [R10]
            strap_taken <= 1'b0;
        end else begin
            if (!strap_taken) begin
                strap_taken <= 1'b1;
                iface_cfg[`RPC_IF_MODE] <= strap_reduced_mode; // [R8] [R9]
            end else if (reg_wr && sel[0]) begin
                iface_cfg <= (reg_wdata & `RPC_IF_WR_MASK) | ({`RPC_RST_IFACE_HI, 8'h00}); // [R15] [R2]
            end
            if (reg_wr && sel[1]) begin
                base_cfg <= (reg_wdata & `RPC_BC_WR_MASK) | {`RPC_RST_BASE_HI, 13'h0000}; // [R15]
            end
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd && sel[0]) begin
                reg_rdata <= iface_cfg;
            end else if (reg_rd && sel[1]) begin
                reg_rdata <= base_cfg;
            end else if (reg_rd) begin
                reg_rdata <= 16'h0000;
            end
        end
    end

    // ----------------------------------------
    // Core defaults
    // ----------------------------------------
    wire fld_core;
    wire pd_core;
    rpc_core_defaults u_core (
        .mclk(mclk),
        .rst_n(rst_n),
        .core_sw_reset(core_sw_reset | ~strap_taken), // [R13]
        .fld_cfg(base_cfg[`RPC_BC_FLD]),
        .pd_cfg(base_cfg[`RPC_BC_SFT_PD]),
        .fast_link_detect_enable_reg(fld_core),
        .sw_powerdown(pd_core)
    );

    // ----------------------------------------
    // Interface behaviour
    // ----------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_fifo_clear <= 1'b0;
            rx_fifo_depth_bits <= `RPC_DEPTH_BASE;
            tx_data_frame_watch_en <= 1'b0;
            tx_frame_start <= 1'b0;
            txd_seen <= 1'b0;
            crs_dv <= 1'b0;
            rx_er <= 1'b0;
            reduced_iface_mode_sel <= 1'b0;
            fast_link_detect_active <= 1'b0;
            sw_powerdown_out <= 1'b0;
        end else begin
            rx_fifo_clear <= iface_cfg[`RPC_IF_FIFO_CLR]; // [R2]
            rx_fifo_depth_bits <= rpc_depth(iface_cfg[`RPC_IF_DEPTH_HI:`RPC_IF_DEPTH_LO]); // [R3]
            tx_data_frame_watch_en <= iface_cfg[`RPC_IF_TXD_WATCH]; // [R4]
            txd_seen <= iface_cfg[`RPC_IF_TXD_WATCH] && (txd != 2'b00);
            tx_frame_start <= iface_cfg[`RPC_IF_TXD_WATCH] && (txd != 2'b00) && !txd_seen; // [R4]
            if (iface_cfg[`RPC_IF_CRS_FOLD]) begin
                crs_dv <= carrier_sense | rx_data_valid; // [R5]
            end else begin
                crs_dv <= rx_data_valid; // [R5]
            end
            if (iface_cfg[`RPC_IF_FC_ERR]) begin
                rx_er <= false_carrier | (symbol_err & in_frame); // [R6]
            end else begin
                rx_er <= symbol_err & in_frame; // [R7]
            end
            reduced_iface_mode_sel <= iface_cfg[`RPC_IF_MODE]; // [R8]
            fast_link_detect_active <= fld_core & link_100_up; // [R11]
            sw_powerdown_out <= pd_core; // [R14]
        end
    end
endmodule

/* logic/rpc_regs.vh */
// Register map and field layout of the MAC interface and power-on default registers.
// Assumes 16-bit subsystem addresses and 16-bit data from the management interface.
`ifndef RPC_REGS_VH
`define RPC_REGS_VH

// ----------------------------------------
// Addresses
// ----------------------------------------
`define RPC_ADDR_IFACE_CFG 16'hFF24
`define RPC_ADDR_BASE_CFG 16'hFF26

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RPC_RST_IFACE_CFG 16'h0116
`define RPC_RST_BASE_CFG 16'h0C86
`define RPC_RST_IFACE_HI 8'h01
`define RPC_RST_BASE_HI 3'h0

// ----------------------------------------
// Interface configuration fields
// ----------------------------------------
`define RPC_IF_FIFO_CLR 7
`define RPC_IF_DEPTH_HI 6
`define RPC_IF_DEPTH_LO 4
`define RPC_IF_TXD_WATCH 3
`define RPC_IF_CRS_FOLD 2
`define RPC_IF_FC_ERR 1
`define RPC_IF_MODE 0
`define RPC_IF_WR_MASK 16'h00FF

// ----------------------------------------
// Base configuration fields
// ----------------------------------------
`define RPC_BC_FLD 10
`define RPC_BC_SFT_PD 3
`define RPC_BC_WR_MASK 16'h1FFF

// ----------------------------------------
// Depth codes
// ----------------------------------------
`define RPC_DEPTH_MAX 3'h5
`define RPC_DEPTH_STEP 5'h04
`define RPC_DEPTH_BASE 5'h04

`endif

/* logic/rpc_core_defaults.v */
// Core-side latch of defaults that only take effect on a core software reset.
// Assumes core_sw_reset is a one-cycle pulse synchronous to mclk.
`timescale 1ns/1ns
module rpc_core_defaults (
    input wire mclk,
    input wire rst_n,
    input wire core_sw_reset,
    input wire fld_cfg,
    input wire pd_cfg,
    output reg fast_link_detect_enable_reg,
    output reg sw_powerdown
);
    // ----------------------------------------
    // Load on core reset only
    // ----------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fast_link_detect_enable_reg <= 1'b1;
            sw_powerdown <= 1'b0;
        end else if (core_sw_reset) begin
            fast_link_detect_enable_reg <= fld_cfg; // [R12]
            sw_powerdown <= pd_cfg; // [R14]
        end
    end
endmodule

/* testbench/rpc_config_regs_props.sv */
// Port-level checker for the configuration register block.
// Assumes it is bound to rpc_config_regs with matching port names.
`timescale 1ns/1ns
module rpc_config_regs_props (
    input wire mclk,
    input wire arst_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    input wire reg_rvalid,
    input wire core_sw_reset,
    input wire link_100_up,
    input wire symbol_err,
    input wire in_frame,
    input wire rx_data_valid,
    input wire rx_fifo_clear,
    input wire [4:0] rx_fifo_depth_bits,
    input wire tx_data_frame_watch_en,
    input wire crs_dv,
    input wire rx_er,
    input wire reduced_iface_mode_sel,
    input wire fast_link_detect_active,
    input wire sw_powerdown_out
);
    // Settles after the internal reset and the strap load are over
    reg [2:0] up;
    wire live = up == 3'h7;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) up <= 3'h0;
        else if (!live) up <= up + 3'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_wr_if; reg_wr && reg_addr == 16'hff24; endsequence
    sequence s_quiet; (live && !core_sw_reset && link_100_up) [*4]; endsequence
    property p_rvalid; reg_rd |=> reg_rvalid; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read gave no valid");
    property p_hi; reg_rd && reg_addr == 16'hff24 |=> reg_rdata[15:8] == 8'h01; endproperty
    a_hi: assert property (p_hi) else $error("high byte wrong");
    property p_fields; s_wr_if |-> ##2 {rx_fifo_clear, tx_data_frame_watch_en, reduced_iface_mode_sel}
        == {$past(reg_wdata[7], 2), $past(reg_wdata[3], 2), $past(reg_wdata[0], 2)}; endproperty
    a_fields: assert property (p_fields) else $error("control bits wrong");
    property p_depth; s_wr_if ##0 reg_wdata[6:4] < 3'h6 |->
        ##2 rx_fifo_depth_bits == 5'h04 + {$past(reg_wdata[6:4], 2), 2'h0}; endproperty
    a_depth: assert property (p_depth) else $error("depth wrong");
    property p_fold; live && rx_data_valid |=> crs_dv; endproperty
    a_fold: assert property (p_fold) else $error("valid lost");
    property p_sym; live && symbol_err && in_frame |=> rx_er; endproperty
    a_sym: assert property (p_sym) else $error("symbol error lost");
    property p_fld_hold; s_quiet |-> $stable(fast_link_detect_active); endproperty
    a_fld_hold: assert property (p_fld_hold) else $error("link detect moved");
    property p_pd_hold; (live && !core_sw_reset) [*4] |-> $stable(sw_powerdown_out); endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("power-down moved");
endmodule

/* testbench/rpc_mac_model.sv */
// Behavioural MAC on the far side of the reduced interface.
// Assumes crs_dv from the block is looped to its transmit side.
`timescale 1ns/1ns
module rpc_mac_model (
    input wire mclk,
    input wire crs_dv,
    output logic [1:0] txd
);
    initial txd = 2'h0;
    // Loopback use: transmit while receive is active, pins low between frames
    always @(posedge mclk) begin
        txd <= crs_dv ? 2'($urandom) : 2'h0;
    end
endmodule

/* testbench/rmii_and_phy_base_config_tb_top.sv */
// Self-checking bench for the configuration register block.
// Assumes rpc_config_regs, the MAC model and the checker are compiled first.
`timescale 1ns/1ns
module rmii_and_phy_base_config_tb_top;
    logic mclk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, strap_reduced_mode = 1, core_sw_reset = 0;
    logic link_100_up = 1, symbol_err = 0, false_carrier = 0, in_frame = 0, carrier_sense = 0, rx_data_valid = 0;
    logic [15:0] reg_addr = '0, reg_wdata = '0, w;
    // Bench copy of the interface register, used to predict crs_dv, rx_er and tx_frame_start
    logic [15:0] ifc = 16'h0116;
    logic exp_dv = 0, exp_er = 0, exp_ts = 0, seen_m = 0;
    int calm = 0;
    wire [15:0] reg_rdata;
    wire [4:0] rx_fifo_depth_bits;
    wire [1:0] txd;
    wire reg_rvalid, rx_fifo_clear, tx_data_frame_watch_en, tx_frame_start, crs_dv, rx_er;
    wire reduced_iface_mode_sel, fast_link_detect_active, sw_powerdown_out;
    wire [2:0] flags = {rx_fifo_clear, tx_data_frame_watch_en, reduced_iface_mode_sel};
    int bad_count = 0, checks_done = 0, cyc = 0;
    initial forever #10 mclk = ~mclk;
    rpc_config_regs dut (.*);
    rpc_mac_model mac (.*);
    always @(posedge mclk) begin
        {carrier_sense, rx_data_valid, symbol_err, false_carrier, in_frame} <= 5'($urandom);
        cyc <= cyc + 1;
        calm <= reg_wr ? 0 : calm + 1;
        exp_dv <= ifc[2] ? (carrier_sense | rx_data_valid) : rx_data_valid;
        exp_er <= ifc[1] ? (false_carrier | (symbol_err & in_frame)) : (symbol_err & in_frame);
        seen_m <= ifc[3] && (txd != 2'h0);
        exp_ts <= ifc[3] && (txd != 2'h0) && !seen_m;
        if (arst_n && cyc > 20 && calm > 2) begin
            chk("crs_dv", {15'h0, exp_dv}, {15'h0, crs_dv});
            chk("rx_er", {15'h0, exp_er}, {15'h0, rx_er});
            chk("tx_frame_start", {15'h0, exp_ts}, {15'h0, tx_frame_start});
        end
        if (cyc == 4000) begin
            bad_count++;
            complete_run();
        end
    end
    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input string n, input [15:0] e, input [15:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic [4:0] exp_depth(input [2:0] c);
        return (c < 3'h6) ? 5'h04 + {c, 2'h0} : 5'h04;
    endfunction
    task wr(input [15:0] a, input [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        if (a == 16'hff24) ifc <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [15:0] a, input [15:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk("rvalid", 16'h0001, {15'h0, reg_rvalid});
        chk("rdata", e, reg_rdata);
    endtask
    task core_chk(input fld, input pd);
        @(posedge mclk);
        core_sw_reset <= 1'b1;
        @(posedge mclk);
        core_sw_reset <= 1'b0;
        repeat (3) @(negedge mclk);
        chk("fld", {15'h0, fld}, {15'h0, fast_link_detect_active});
        chk("pd", {15'h0, pd}, {15'h0, sw_powerdown_out});
    endtask
    initial begin
        void'($urandom(32'h4b80));
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(16'hff24, 16'h0117);
        rd(16'hff26, 16'h0c86);
        chk("depth", 16'h0008, {11'h0, rx_fifo_depth_bits});
        chk("fld", 16'h0001, {15'h0, fast_link_detect_active});
        $display("reset values done");
        for (int i = 0; i < 12; i++) begin
            w = 16'($urandom);
            if (i < 2) w[6:4] = 3'h6 + i[2:0];
            wr(16'hff24, w);
            rd(16'hff24, {8'h01, w[7:0]});
            chk("depth", {11'h0, exp_depth(w[6:4])}, {11'h0, rx_fifo_depth_bits});
            chk("flags", {13'h0, w[7], w[3], w[0]}, {13'h0, flags});
            wr(16'hff26, w);
            rd(16'hff26, {3'h0, w[12:0]});
        end
        $display("register loop done");
        wr(16'hff26, 16'h0008);
        repeat (3) @(negedge mclk);
        chk("fld", 16'h0001, {15'h0, fast_link_detect_active});
        core_chk(1'b0, 1'b1);
        wr(16'hff26, 16'h0400);
        core_chk(1'b1, 1'b0);
        wr(16'hff25, 16'hffff);
        rd(16'hff25, 16'h0000);
        rd(16'hff24, {8'h01, w[7:0]});
        $display("core reset done");
        complete_run();
    end
endmodule
bind rpc_config_regs rpc_config_regs_props u_props (.*);
